// ===== logic/crs_defines.vh
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

// Clock rate in kHz and figures of the sequence
`define CRS_CLK_KHZ 25000
`define CRS_RC_ONLY_CYCLES 1024
`define CRS_PIN_LOW_NS 1000
// Least time rounds up to whole cycles
`define CRS_PIN_LOW_CYCLES ((`CRS_PIN_LOW_NS * `CRS_CLK_KHZ + 999999) / 1000000)
`define CRS_STRETCH_CYCLES 4096
`define CRS_XTAL_MISS_DEF 16
`define CRS_SST_TIMEOUT_DEF 65536
// Start address of the processor
`define CRS_RESET_VECTOR 16'h0000
// Interface select strap codes
`define CRS_IF_UART 2'h0
`define CRS_IF_SPI 2'h1
`define CRS_IF_I2C 2'h2
// Status flag position
`define CRS_STAT_XTAL_FAIL 0

`endif

// ===== logic/crs_sync2.v
`timescale 1ns/1ns
// Two-flop synchroniser for one pin
module crs_sync2 (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Data
    input wire din,
    output wire dout
);
reg meta;
reg stable;

// First flop read only by the second
always @(posedge clk or posedge rst) begin
    if (rst) begin
        meta <= 1'b0;
        stable <= 1'b0;
    end else begin
        meta <= din;
        stable <= meta;
    end
end

assign dout = stable;

endmodule // crs_sync2

// ===== logic/crs_clock_reset_supervisor.v
// Behaviour
// - Run on RC for first 1024 cycles
// - Then switch to external clock automatically
// - External failure returns to RC clock
// - Failure flag shown in status
// - Reset pin low halts all but clocking
// - Power-on detector starts and forces reset
// - Reset pin counts only after 1us low
// - Hold reset until pin high plus 4096
// - Processor starts at address zero
// - Supervision timeout starts full reset
// - Straps sampled at reset choose interface
// - Only one host interface enabled
`timescale 1ns/1ns
`include "crs_defines.vh"
module crs_clock_reset_supervisor #(
    parameter XTAL_MISS = `CRS_XTAL_MISS_DEF,
    parameter SST_TIMEOUT = `CRS_SST_TIMEOUT_DEF
) (
    // Clock (internal RC) and asynchronous reset
    input wire clk,
    input wire rst,
    // Power-on detector, high while supply valid
    input wire supply_ok,
    // Active-low reset pin
    input wire reset_pin_n,
    // External oscillator activity (raw, sampled here)
    input wire xtal_clk_in,
    // Supervision timer refresh from processor
    input wire sst_refresh,
    // Strap pins
    input wire [1:0] strap_if_sel,
    input wire [1:0] strap_addr,
    // Clock selection and status
    output reg clk_sel_ext,
    output reg status_xtal_fail,
    // Internal reset to digital core
    output reg core_reset,
    output reg [15:0] fetch_addr,
    // Host interface enables and address
    output reg if_uart_en,
    output reg if_spi_en,
    output reg if_i2c_en,
    output reg [1:0] dev_addr
);

// Reset sequencer states, one-hot
// Any illegal code falls back to hold
localparam ST_HOLD = 3'b001;
localparam ST_STRETCH = 3'b010;
localparam ST_RUN = 3'b100;

wire supply_s;
wire pin_s;
wire xtal_s;
wire [1:0] if_s;
wire [1:0] addr_s;

// Every asynchronous pin passes two flops
// Straps are static levels, so per-bit sync is safe for them

// Power detector
crs_sync2 u_sync_sup (
    .clk(clk),
    .rst(rst),
    .din(supply_ok),
    .dout(supply_s)
);

// Reset pin
crs_sync2 u_sync_pin (
    .clk(clk),
    .rst(rst),
    .din(reset_pin_n),
    .dout(pin_s)
);

// Crystal activity, sampled as data
crs_sync2 u_sync_xtal (
    .clk(clk),
    .rst(rst),
    .din(xtal_clk_in),
    .dout(xtal_s)
);

// Interface select strap, low bit
crs_sync2 u_sync_if0 (
    .clk(clk),
    .rst(rst),
    .din(strap_if_sel[0]),
    .dout(if_s[0])
);

// Interface select strap, high bit
crs_sync2 u_sync_if1 (
    .clk(clk),
    .rst(rst),
    .din(strap_if_sel[1]),
    .dout(if_s[1])
);

// Address strap, low bit
crs_sync2 u_sync_ad0 (
    .clk(clk),
    .rst(rst),
    .din(strap_addr[0]),
    .dout(addr_s[0])
);

// Address strap, high bit
crs_sync2 u_sync_ad1 (
    .clk(clk),
    .rst(rst),
    .din(strap_addr[1]),
    .dout(addr_s[1])
);

// Sequencer
reg [2:0] state;
reg [2:0] next_state;
reg [12:0] stretch_cnt;

// Reset pin filter
reg [4:0] low_cnt;
reg pin_req;
wire pin_low;

// Supervision timer
reg [16:0] sst_cnt;
reg sst_fire;

// Clock manager and crystal activity
reg [10:0] rc_cnt;
reg [7:0] miss_cnt;
reg xtal_d;
wire xtal_edge;
wire xtal_dead;
wire rc_done;

assign pin_low = ~pin_s;
assign xtal_edge = xtal_s ^ xtal_d;

// Crystal counted dead once the miss count is full
assign xtal_dead = (miss_cnt == XTAL_MISS[7:0]) && !xtal_edge;
// RC-only window over
assign rc_done = (rc_cnt == `CRS_RC_ONLY_CYCLES);

// glitch filter
// Pin low must persist the full count; any high restarts it
always @(posedge clk or posedge rst) begin
    if (rst) begin
        low_cnt <= 5'h00;
        pin_req <= 1'b0;
    end else if (!pin_low) begin
        low_cnt <= 5'h00;
        pin_req <= 1'b0;
    end else if (low_cnt >= `CRS_PIN_LOW_CYCLES - 1) begin
        pin_req <= 1'b1;
    end else begin
        low_cnt <= low_cnt + 5'h01;
    end
end

// Sequencer next state
// Causes come last so they override the order
always @* begin
    next_state = state;
    case (state)
    ST_HOLD: begin
        if (supply_s && !pin_req && pin_s)
            next_state = ST_STRETCH;
    end
    ST_STRETCH: begin
        if (stretch_cnt == `CRS_STRETCH_CYCLES - 1)
            next_state = ST_RUN;
    end
    ST_RUN: begin
        next_state = ST_RUN;
    end
    default: next_state = ST_HOLD;
    endcase
    if (!supply_s)
        next_state = ST_HOLD;
    if (pin_req)
        next_state = ST_HOLD;
    if (sst_fire)
        next_state = ST_HOLD;
end

// Sequencer state and stretch timer
always @(posedge clk or posedge rst) begin
    if (rst) begin
        state <= ST_HOLD;
        stretch_cnt <= 13'h0000;
    end else begin
        state <= next_state;
        if (state == ST_STRETCH && next_state == ST_STRETCH)
            stretch_cnt <= stretch_cnt + 13'h0001;
        else
            stretch_cnt <= 13'h0000;
    end
end

// Core reset and program counter start point
// Registered so the core never sees a decode glitch
always @(posedge clk or posedge rst) begin
    if (rst) begin
        core_reset <= 1'b1;
        fetch_addr <= `CRS_RESET_VECTOR;
    end else begin
        core_reset <= (next_state != ST_RUN);
        if (next_state != ST_RUN)
            fetch_addr <= `CRS_RESET_VECTOR;
    end
end

// Supervision timer, free running while the core runs
// Refresh wins even when it comes on the final count
// Held clear outside run, so each start gets a full span
always @(posedge clk or posedge rst) begin
    if (rst) begin
        sst_cnt <= 17'h00000;
        sst_fire <= 1'b0;
    end else if (state != ST_RUN || sst_refresh) begin
        sst_cnt <= 17'h00000;
        sst_fire <= 1'b0;
    end else if (sst_cnt == SST_TIMEOUT[16:0] - 17'h00001) begin
        sst_cnt <= 17'h00000;
        sst_fire <= 1'b1;
    end else begin
        sst_cnt <= sst_cnt + 17'h00001;
        sst_fire <= 1'b0;
    end
end

// missing-edge detector
// Saturates, so a long dead spell never wraps to look alive
always @(posedge clk or posedge rst) begin
    if (rst) begin
        xtal_d <= 1'b0;
        miss_cnt <= 8'h00;
    end else begin
        xtal_d <= xtal_s;
        if (!supply_s || xtal_edge)
            miss_cnt <= 8'h00;
        else if (miss_cnt != XTAL_MISS[7:0])
            miss_cnt <= miss_cnt + 8'h01;
    end
end

// Clock manager keeps running through pin reset
// Only the power detector restarts its RC-only window
always @(posedge clk or posedge rst) begin
    if (rst) begin
        rc_cnt <= 11'h000;
        clk_sel_ext <= 1'b0;
        status_xtal_fail <= 1'b0;
    end else if (!supply_s) begin
        rc_cnt <= 11'h000;
        clk_sel_ext <= 1'b0;
    end else begin
        if (!rc_done)
            rc_cnt <= rc_cnt + 11'h001;
        if (xtal_dead) begin
            clk_sel_ext <= 1'b0;
            // failure flag after use
            // Sticky until a live crystal is selected again
            if (clk_sel_ext)
                status_xtal_fail <= 1'b1;
        end else if (rc_done && xtal_edge) begin
            clk_sel_ext <= 1'b1;
            status_xtal_fail <= 1'b0;
        end
    end
end

// Strap capture while core held in reset
// Straps follow the pins through hold, frozen on release
always @(posedge clk or posedge rst) begin
    if (rst) begin
        if_uart_en <= 1'b0;
        if_spi_en <= 1'b0;
        if_i2c_en <= 1'b0;
        dev_addr <= 2'h0;
    end else if (state == ST_HOLD) begin
        dev_addr <= addr_s;
        if_uart_en <= (if_s == `CRS_IF_UART) || (if_s == 2'h3);
        if_spi_en <= (if_s == `CRS_IF_SPI);
        if_i2c_en <= (if_s == `CRS_IF_I2C);
    end
end

endmodule // crs_clock_reset_supervisor

// ===== testbench/crs_sup_asserts.sv
`timescale 1ns/1ns
// Sees only the supervisor ports
module crs_sup_asserts #(
    parameter XTAL_MISS = 16,
    parameter SST_TIMEOUT = 65536
) (
    input wire clk,
    input wire rst,
    input wire supply_ok,
    input wire reset_pin_n,
    input wire xtal_clk_in,
    input wire sst_refresh,
    input wire clk_sel_ext,
    input wire status_xtal_fail,
    input wire core_reset,
    input wire [15:0] fetch_addr,
    input wire if_uart_en,
    input wire if_spi_en,
    input wire if_i2c_en
);
    reg [12:0] hi_cnt;
    reg [5:0] still;
    reg [17:0] idle;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // hi_cnt and still saturate, so long runs never wrap them into false alarms; idle does not saturate
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_cnt <= 13'h0;
            still <= 6'h0;
            idle <= 18'h0;
        end else begin
            hi_cnt <= reset_pin_n && supply_ok ?
                hi_cnt + {12'h0, !hi_cnt[12]} : 13'h0;
            still <= $stable(xtal_clk_in) ? still + {5'h0, !still[5]} : 6'h0;
            idle <= core_reset || sst_refresh ? 18'h0 : idle + 18'h1;
        end
    end
    a_fetch_zero: assert property (core_reset |-> fetch_addr == 16'h0)
        else $error("fetch address not zero");
    a_one_host: assert property (
        !core_reset |-> $onehot({if_uart_en, if_spi_en, if_i2c_en}))
        else $error("host enables not one-hot");
    a_xtal_dead: assert property (
        still > XTAL_MISS + 8 |-> !clk_sel_ext)
        else $error("dead crystal still selected");
    a_fail_flag: assert property (
        $fell(clk_sel_ext) && still > 6'h8 |-> ##[0:2] status_xtal_fail)
        else $error("failure flag missing");
    a_stretch_len: assert property ($fell(core_reset) |-> hi_cnt[12])
        else $error("reset released early");
    a_pin_reset: assert property (
        $fell(reset_pin_n) |-> ##[0:40] (core_reset || reset_pin_n))
        else $error("held pin gave no reset");
    a_supply_loss: assert property ((!supply_ok) [*6] |-> core_reset)
        else $error("no reset on supply loss");
    a_sst_fire: assert property (idle <= SST_TIMEOUT + 8)
        else $error("timeout gave no reset");
endmodule // crs_sup_asserts

// ===== testbench/crs_board.sv
`timescale 1ns/1ns
// Crystal and processor software around the block
module crs_board (
    // Clock and controls
    input wire clk,
    input wire xtal_on,
    input wire sw_alive,
    // Towards the block
    output reg xtal_clk_in,
    output reg sst_refresh
);
    reg [3:0] tick = 4'h0;
    initial xtal_clk_in = 1'b0;
    initial sst_refresh = 1'b0;
    // A stopped crystal holds its level, like a real dead one
    always @(negedge clk) begin
        if (xtal_on) xtal_clk_in <= ~xtal_clk_in;
        tick <= tick + 4'h1;
        sst_refresh <= sw_alive && tick == 4'hf;
    end
endmodule // crs_board

// ===== testbench/test_clock_reset_supervisor.sv
`timescale 1ns/1ns
module test_clock_reset_supervisor;
    localparam XTAL_MISS = 16;
    localparam SST_TIMEOUT = 64;
    reg clk, rst, supply_ok, reset_pin_n, xtal_on, sw_alive;
    reg [1:0] strap_if_sel, strap_addr;
    wire xtal_clk_in, sst_refresh, clk_sel_ext, status_xtal_fail, core_reset;
    wire if_uart_en, if_spi_en, if_i2c_en;
    wire [1:0] dev_addr;
    wire [15:0] fetch_addr;
    wire [2:0] ifs = {if_uart_en, if_spi_en, if_i2c_en};
    integer n_mismatch, samples_checked, n, k;
    crs_clock_reset_supervisor #(.XTAL_MISS(XTAL_MISS),
        .SST_TIMEOUT(SST_TIMEOUT)) crs_clock_reset_supervisor_i (.clk, .rst,
        .supply_ok, .reset_pin_n, .xtal_clk_in, .sst_refresh, .strap_if_sel,
        .strap_addr, .clk_sel_ext, .status_xtal_fail, .core_reset,
        .fetch_addr, .if_uart_en, .if_spi_en, .if_i2c_en, .dev_addr);
    crs_board crs_board_i (.clk, .xtal_on, .sw_alive, .xtal_clk_in,
        .sst_refresh);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task chk(input [15:0] seen, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(negedge clk);
    endtask
    // Bounded wait, so a stuck reset shows as a mismatch
    task wait_rel;
        for (n = 0; core_reset !== 1'b0 && n < 6000; n = n + 1) cyc(1);
    endtask
    task t_power;
        cyc(20);
        chk(core_reset, 1'h1);
        supply_ok = 1'b1;
        cyc(1000);
        chk(clk_sel_ext, 1'h0);
        cyc(100);
        chk(clk_sel_ext, 1'h1);
        wait_rel;
        chk(core_reset, 1'h0);
        chk(fetch_addr, 16'h0000);
        chk(ifs, 3'h2);
        chk(dev_addr, 2'h2);
        $display("power done");
    endtask
    task t_xfail;
        xtal_on = 1'b0;
        cyc(XTAL_MISS + 10);
        chk(clk_sel_ext, 1'h0);
        chk(status_xtal_fail, 1'h1);
        xtal_on = 1'b1;
        cyc(40);
        chk(clk_sel_ext, 1'h1);
        chk(status_xtal_fail, 1'h0);
        $display("xtal done");
    endtask
    task t_pin(input [1:0] code);
        strap_if_sel = code;
        strap_addr = ~code;
        reset_pin_n = 1'b0;
        cyc(20);
        reset_pin_n = 1'b1;
        cyc(10);
        chk(core_reset, 1'h0);
        reset_pin_n = 1'b0;
        cyc(60);
        chk(core_reset, 1'h1);
        chk(clk_sel_ext, 1'h1);
        reset_pin_n = 1'b1;
        wait_rel;
        chk(n >= 4096 && n <= 4110, 1'h1);
        chk(ifs, code == 2'h1 ? 3'h2 : code == 2'h2 ? 3'h1 : 3'h4);
        chk(dev_addr, {14'h0, ~code});
        $display("pin done");
    endtask
    task t_cause;
        sw_alive = 1'b0;
        cyc(SST_TIMEOUT + 12);
        chk(core_reset, 1'h1);
        sw_alive = 1'b1;
        wait_rel;
        chk(core_reset, 1'h0);
        supply_ok = 1'b0;
        cyc(6);
        chk(core_reset, 1'h1);
        supply_ok = 1'b1;
        wait_rel;
        chk(core_reset, 1'h0);
        $display("cause done");
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #2400000;
        n_mismatch = n_mismatch + 1;
        close_out;
    end
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        {rst, reset_pin_n, xtal_on, sw_alive} = 4'hf;
        supply_ok = 1'b0;
        strap_if_sel = 2'h1;
        strap_addr = 2'h2;
        cyc(8);
        rst = 1'b0;
        t_power;
        t_xfail;
        for (k = 0; k < 4; k = k + 1) t_pin(k[1:0]);
        t_cause;
        close_out;
    end
endmodule // test_clock_reset_supervisor
bind crs_clock_reset_supervisor crs_sup_asserts #(.XTAL_MISS(XTAL_MISS),
    .SST_TIMEOUT(SST_TIMEOUT)) crs_sup_asserts_i (.clk, .rst, .supply_ok,
    .reset_pin_n, .xtal_clk_in, .sst_refresh, .clk_sel_ext,
    .status_xtal_fail, .core_reset, .fetch_addr, .if_uart_en, .if_spi_en,
    .if_i2c_en);
